// *** rtl/tx_local_segmented_bus_pkg.sv ***
package tx_local_segmented_bus_pkg;
`include "tx_local_segmented_bus_regs.svh"

	typedef struct packed {
		logic [`TX_SEG_DATA_W-1:0] data;
		logic                      valid;
		logic                      first;
		logic                      last;
		logic                      abort;
		logic [`TX_EMPTY_W-1:0]    empty_count;
	} seg_s;

	typedef seg_s [`TX_SEG_COUNT-1:0] beat_t;

	typedef enum logic [2:0] {
		LINE_IDLE    = 3'b001,
		LINE_PACKET  = 3'b010,
		LINE_CORRUPT = 3'b100
	} line_state_e;
endpackage

// *** rtl/tx_local_segmented_bus_regs.svh ***
// Notes on behaviour
// [RQ1] Accept-ready is high whenever the transmit path has room for more data; here it goes low once the buffer holds 9 of its 16 entries.
// [RQ2] User logic stops presenting transfers within four cycles after accept-ready drops.
// [RQ3] After a mid-packet pause, user logic resumes within 4 cycles of accept-ready rising.
// [RQ4] Overflow flag rises when transfers continue beyond the allowed stop window.
// [RQ5] After overflow the transmit path must be reset; user logic must avoid overflow.
// [RQ6] Underflow flag rises when data runs dry mid-packet; that packet is corrupted.
// [RQ7] While underflow lasts, error control blocks go out instead of packet data.
// [RQ8] User logic delivers each packet first to last without starving gaps.
// [RQ9] Four 128-bit segments; a segment's data is captured whenever its valid is high.
// [RQ10] Every qualifier and data input is ignored while that segment's valid is low.
// [RQ11] First-transfer marker is high only on the transfer that starts a packet.
// [RQ12] Last-transfer marker is high only on the final transfer of a packet.
// [RQ13] Abort on the last transfer swaps in the error word and skips FCS for it.
// [RQ14] Empty count gives invalid bytes; with abort its low three bits read as 000.
// [RQ15] Bus signals registered on the transmit clock; outputs inactive during reset.
`ifndef TX_LOCAL_SEGMENTED_BUS_REGS_SVH
`define TX_LOCAL_SEGMENTED_BUS_REGS_SVH

// ----------------------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------------------
`define TX_SEG_COUNT      4
`define TX_SEG_DATA_W     128
`define TX_EMPTY_W        4
`define TX_EMPTY_KEEP_MSB 3
`define TX_EMPTY_LOW_ZERO 3'h0

// ----------------------------------------------------------------------------
// Timing and buffer sizing
// ----------------------------------------------------------------------------
`define TX_STOP_WINDOW    4
`define TX_RESUME_WINDOW  4
`define TX_FIFO_DEPTH     16
`define TX_READY_HEADROOM (`TX_STOP_WINDOW + 3)

// ----------------------------------------------------------------------------
// Error control word sent in place of data
// ----------------------------------------------------------------------------
`define TX_ERROR_WORD     128'hfefefefefefefefefefefefefefefe1e

`endif

// *** rtl/tx_local_segmented_bus_top.sv ***
`timescale 1ns/1ps
`include "tx_local_segmented_bus_regs.svh"
module tx_local_segmented_bus_top
	import tx_local_segmented_bus_pkg::*;
#(
	parameter int FIFO_DEPTH = `TX_FIFO_DEPTH
) (
	input  wire logic                                          clock,
	input  wire logic                                          rst_n,
	input  wire logic [`TX_SEG_COUNT-1:0][`TX_SEG_DATA_W-1:0]  tx_segment_data,
	input  wire logic [`TX_SEG_COUNT-1:0]                      tx_segment_valid,
	input  wire logic [`TX_SEG_COUNT-1:0]                      tx_segment_first,
	input  wire logic [`TX_SEG_COUNT-1:0]                      tx_segment_last,
	input  wire logic [`TX_SEG_COUNT-1:0]                      tx_segment_abort,
	input  wire logic [`TX_SEG_COUNT-1:0][`TX_EMPTY_W-1:0]     tx_segment_empty_count,
	output logic                                               tx_accept_ready,
	output logic                                               tx_overflow_flag,
	output logic                                               tx_underflow_flag,
	input  wire logic                                          line_ready,
	output logic                                               line_valid,
	output beat_t                                              line_beat,
	output logic                                               line_error_block,
	output logic                                               line_fcs_skip
);
	localparam int PTR_W = $clog2(FIFO_DEPTH);
	localparam int CNT_W = PTR_W + 1;
	localparam logic [CNT_W-1:0] READY_LIMIT = CNT_W'(FIFO_DEPTH - `TX_READY_HEADROOM);
	localparam logic [CNT_W-1:0] FULL_COUNT  = CNT_W'(FIFO_DEPTH);
	localparam logic [3:0]       STOP_LIMIT  = 4'(`TX_STOP_WINDOW);

	// ------------------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------------------
	logic rst_meta_reg;
	logic rst_sync_n;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_n   <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_n   <= rst_meta_reg;
		end
	end

	// ------------------------------------------------------------------------
	// Segment capture stage
	// ------------------------------------------------------------------------
	beat_t cap_beat;

	for (genvar s = 0; s < `TX_SEG_COUNT; s++) begin : g_seg
		tx_segment_capture u_capture (
			.clock           (clock),
			.rst_sync_n      (rst_sync_n),
			.seg_data        (tx_segment_data[s]),
			.seg_valid       (tx_segment_valid[s]),
			.seg_first       (tx_segment_first[s]),
			.seg_last        (tx_segment_last[s]),
			.seg_abort       (tx_segment_abort[s]),
			.seg_empty_count (tx_segment_empty_count[s]),
			.seg_reg         (cap_beat[s])
		);
	end

	// Packet state after walking the four segments of a beat in order.
	function automatic logic walk_packet(input beat_t beat, input logic in_packet);
		logic state;
		state = in_packet;
		for (int s = 0; s < `TX_SEG_COUNT; s++) begin
			if (beat[s].valid && beat[s].first)
				state = 1'b1;
			if (beat[s].valid && beat[s].last)
				state = 1'b0;
		end
		return state;
	endfunction

	function automatic logic beat_has_valid(input beat_t beat);
		logic any;
		any = 1'b0;
		for (int s = 0; s < `TX_SEG_COUNT; s++)
			any = any | beat[s].valid;
		return any;
	endfunction

	// ------------------------------------------------------------------------
	// Transmit buffer
	// ------------------------------------------------------------------------
	beat_t            fifo_mem [FIFO_DEPTH];
	logic [PTR_W-1:0] wr_ptr_reg;
	logic [PTR_W-1:0] rd_ptr_reg;
	logic [CNT_W-1:0] count_reg;

	wire logic cap_any   = beat_has_valid(cap_beat);
	wire logic fifo_full = (count_reg == FULL_COUNT);
	wire logic fifo_empty = (count_reg == '0);
	wire logic push      = cap_any && !fifo_full;
	wire logic pop       = line_ready && !fifo_empty;

	always_ff @(posedge clock) begin
		if (push)
			fifo_mem[wr_ptr_reg] <= cap_beat;
	end

	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			wr_ptr_reg <= push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
			rd_ptr_reg <= pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
			count_reg  <= count_reg + CNT_W'(push) - CNT_W'(pop);
		end
	end

	// ------------------------------------------------------------------------
	// Back-pressure and overflow
	// ------------------------------------------------------------------------
	// Headroom covers the stop window plus the input and ready registers, so a
	// source that obeys the window never meets a full buffer.
	logic       ready_reg;
	logic       overflow_reg;
	logic [3:0] low_cnt_reg;
	logic [3:0] low_cnt_seen_reg;

	wire logic ready_next   = (count_reg < READY_LIMIT) && !overflow_reg; // [RQ1]
	wire logic late_beat    = cap_any && (low_cnt_seen_reg > STOP_LIMIT); // [RQ4]
	wire logic overflow_next = overflow_reg || late_beat || (cap_any && fifo_full);
	wire logic [3:0] low_cnt_next = ready_reg ? 4'h0 :
		((low_cnt_reg == 4'hf) ? low_cnt_reg : low_cnt_reg + 4'h1);

	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ready_reg        <= 1'b0; // [RQ15]
			overflow_reg     <= 1'b0;
			low_cnt_reg      <= 4'h0;
			low_cnt_seen_reg <= 4'h0;
		end else begin
			ready_reg        <= ready_next;
			// Overflow holds until the transmit path is reset.
			overflow_reg     <= overflow_next; // [RQ4] [RQ5]
			low_cnt_reg      <= low_cnt_next;
			low_cnt_seen_reg <= low_cnt_next;
		end
	end

	// ------------------------------------------------------------------------
	// Line side and underflow
	// ------------------------------------------------------------------------
	line_state_e state_reg;
	beat_t       line_beat_reg;
	logic        line_valid_reg;
	logic        line_error_reg;
	logic        fcs_skip_reg;
	logic        underflow_reg;

	beat_t       head_beat;
	beat_t       error_beat;
	assign head_beat = fifo_mem[rd_ptr_reg];

	for (genvar s = 0; s < `TX_SEG_COUNT; s++) begin : g_err
		assign error_beat[s] = '{data: `TX_ERROR_WORD, valid: 1'b1, first: 1'b0,
			last: head_beat[s].last && pop, abort: 1'b0, empty_count: 4'h0};
	end

	wire logic in_packet = (state_reg != LINE_IDLE);
	wire logic starving  = line_ready && fifo_empty && in_packet; // [RQ6]
	wire logic head_ends = pop && !walk_packet(head_beat, in_packet);
	wire logic send_err  = starving || (pop && state_reg == LINE_CORRUPT); // [RQ7]
	wire logic head_abort = |{head_beat[3].abort, head_beat[2].abort,
		head_beat[1].abort, head_beat[0].abort};

	line_state_e state_next;
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			LINE_IDLE:
				if (pop && walk_packet(head_beat, 1'b0))
					state_next = LINE_PACKET;
			LINE_PACKET:
				if (starving)
					state_next = LINE_CORRUPT;
				else if (head_ends)
					state_next = LINE_IDLE;
			LINE_CORRUPT:
				if (head_ends)
					state_next = LINE_IDLE;
			default:
				state_next = LINE_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state_reg      <= LINE_IDLE;
			line_beat_reg  <= '0;
			line_valid_reg <= 1'b0;
			line_error_reg <= 1'b0;
			fcs_skip_reg   <= 1'b0;
			underflow_reg  <= 1'b0;
		end else begin
			state_reg      <= state_next;
			line_beat_reg  <= send_err ? error_beat : (pop ? head_beat : '0); // [RQ7]
			line_valid_reg <= pop || starving;
			line_error_reg <= send_err;
			fcs_skip_reg   <= pop && head_abort; // [RQ13]
			underflow_reg  <= starving; // [RQ6]
		end
	end

	assign tx_accept_ready   = ready_reg;
	assign tx_overflow_flag  = overflow_reg;
	assign tx_underflow_flag = underflow_reg;
	assign line_valid        = line_valid_reg;
	assign line_beat         = line_beat_reg;
	assign line_error_block  = line_error_reg;
	assign line_fcs_skip     = fcs_skip_reg;

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	ready_room_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // [RQ1]
		count_reg >= READY_LIMIT |=> !tx_accept_ready)
		else $error("ready high with no headroom");
	ready_return_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // [RQ1]
		count_reg < READY_LIMIT && !overflow_reg |=> tx_accept_ready)
		else $error("ready low although room exists");
	late_beat_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // [RQ4]
		cap_any && low_cnt_seen_reg > STOP_LIMIT |=> tx_overflow_flag)
		else $error("late transfer not flagged as overflow");
	overflow_hold_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // [RQ5]
		tx_overflow_flag |=> tx_overflow_flag && !tx_accept_ready)
		else $error("overflow cleared without reset");
	starve_flag_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // [RQ6]
		starving |=> tx_underflow_flag ##0 line_error_block ##1 state_reg != LINE_PACKET)
		else $error("starved packet not flagged");
	underflow_block_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // [RQ7]
		tx_underflow_flag |-> line_valid && line_error_block
			&& line_beat[0].data == `TX_ERROR_WORD)
		else $error("no error block during underflow");
	fcs_skip_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // [RQ13]
		pop && head_abort |=> line_fcs_skip)
		else $error("aborted packet kept FCS");
endmodule

// *** rtl/tx_segment_capture.sv ***
`timescale 1ns/1ps
`include "tx_local_segmented_bus_regs.svh"
module tx_segment_capture
	import tx_local_segmented_bus_pkg::*;
(
	input  wire logic                      clock,
	input  wire logic                      rst_sync_n,
	input  wire logic [`TX_SEG_DATA_W-1:0] seg_data,
	input  wire logic                      seg_valid,
	input  wire logic                      seg_first,
	input  wire logic                      seg_last,
	input  wire logic                      seg_abort,
	input  wire logic [`TX_EMPTY_W-1:0]    seg_empty_count,
	output seg_s                           seg_reg
);
	// ------------------------------------------------------------------------
	// Qualify and transform one segment
	// ------------------------------------------------------------------------
	wire logic                   abort_last = seg_valid && seg_last && seg_abort;
	wire logic [`TX_EMPTY_W-1:0] empty_used = abort_last ?
		{seg_empty_count[`TX_EMPTY_KEEP_MSB], `TX_EMPTY_LOW_ZERO} : seg_empty_count; // [RQ14]
	seg_s seg_next;

	always_comb begin
		seg_next = '0; // [RQ10]
		if (seg_valid) begin
			seg_next.data        = abort_last ? `TX_ERROR_WORD : seg_data; // [RQ9] [RQ13]
			seg_next.valid       = 1'b1;
			seg_next.first       = seg_first;
			seg_next.last        = seg_last;
			seg_next.abort       = abort_last;
			// Empty count only means something on the last transfer.
			seg_next.empty_count = seg_last ? empty_used : 4'h0;
		end
	end

	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n)
			seg_reg <= '0;
		else
			seg_reg <= seg_next; // [RQ15]
	end

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	capture_data_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // [RQ9]
		seg_valid && !abort_last |=> seg_reg.valid && seg_reg.data == $past(seg_data))
		else $error("valid segment data not captured");
	ignore_idle_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // [RQ10]
		!seg_valid |=> seg_reg == '0)
		else $error("idle segment inputs leaked through");
	abort_word_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // [RQ13]
		abort_last |=> seg_reg.data == `TX_ERROR_WORD && seg_reg.abort)
		else $error("aborted last word not replaced");
	empty_mask_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // [RQ14]
		abort_last |=> seg_reg.empty_count[2:0] == 3'h0
			&& seg_reg.empty_count[3] == $past(seg_empty_count[3]))
		else $error("empty count not masked on abort");
endmodule

// *** tb/packet_source.sv ***
`timescale 1ns/1ps
`include "tx_local_segmented_bus_regs.svh"
module packet_source
	import tx_local_segmented_bus_pkg::*;
(
	input  wire logic                                          clock,
	input  wire logic                                          rst_n,
	input  wire logic                                          tx_accept_ready,
	input  wire logic                                          run,
	input  wire logic                                          obey,
	input  wire logic                                          starve,
	input  wire logic [1:0]                                    lag,
	output logic      [`TX_SEG_COUNT-1:0][`TX_SEG_DATA_W-1:0]  seg_data,
	output logic      [`TX_SEG_COUNT-1:0]                      seg_valid,
	output logic      [`TX_SEG_COUNT-1:0]                      seg_first,
	output logic      [`TX_SEG_COUNT-1:0]                      seg_last,
	output logic      [`TX_SEG_COUNT-1:0]                      seg_abort,
	output logic      [`TX_SEG_COUNT-1:0][`TX_EMPTY_W-1:0]     seg_empty,
	output logic                                               mid_packet
);
	logic [2:0] ready_hist;
	int         beats_left;
	int         nseg;

	// ------------------------------------------------------------------------
	// Packet generator
	// ------------------------------------------------------------------------
	// A lag of at most 2 keeps the reaction to accept-ready inside 4 cycles.
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ready_hist <= '0;
			seg_valid  <= '0;
			mid_packet <= 1'b0;
			beats_left = 0;
		end else begin
			ready_hist <= {ready_hist[1:0], tx_accept_ready};
			// Idle lanes carry a fresh pattern every cycle, so stale values cannot pass.
			for (int s = 0; s < 4; s++) begin
				seg_data[s]  <= {$urandom, $urandom, $urandom, $urandom};
				seg_first[s] <= 1'($urandom);
				seg_last[s]  <= 1'($urandom);
				seg_abort[s] <= 1'($urandom);
				seg_empty[s] <= 4'($urandom);
			end
			seg_valid <= '0;
			if (run && !starve && (!obey || ready_hist[lag])) begin
				if (!mid_packet) begin
					beats_left = $urandom_range(0, 3);
				end
				nseg = (beats_left == 0) ? $urandom_range(1, 4) : 4;
				for (int s = 0; s < 4; s++) begin
					seg_valid[s] <= (s < nseg);
					seg_first[s] <= (s == 0) && !mid_packet;
					seg_last[s]  <= (s == nseg - 1) && (beats_left == 0);
					seg_abort[s] <= ($urandom_range(0, 3) == 0);
				end
				mid_packet <= (beats_left != 0);
				beats_left--;
			end
		end
	end
endmodule

// *** tb/tx_local_segmented_bus_top_bench.sv ***
`timescale 1ns/1ps
`include "tx_local_segmented_bus_regs.svh"
module tx_local_segmented_bus_top_bench
	import tx_local_segmented_bus_pkg::*;
;
	logic                                      clock;
	logic                                      rst_n;
	logic                                      run;
	logic                                      obey;
	logic                                      starve;
	logic [1:0]                                lag;
	logic                                      line_ready;
	logic                                      chk;
	logic [3:0][127:0]                         tx_segment_data;
	logic [3:0]                                tx_segment_valid;
	logic [3:0]                                tx_segment_first;
	logic [3:0]                                tx_segment_last;
	logic [3:0]                                tx_segment_abort;
	logic [3:0][3:0]                           tx_segment_empty_count;
	logic                                      mid_packet;
	logic                                      tx_accept_ready;
	logic                                      tx_overflow_flag;
	logic                                      tx_underflow_flag;
	logic                                      line_valid;
	beat_t                                     line_beat;
	logic                                      line_error_block;
	logic                                      line_fcs_skip;
	beat_t                                     q[$];
	beat_t                                     pend;
	logic                                      pend_v;
	beat_t                                     pend2;
	logic                                      pend2_v;
	logic                                      lr_prev;
	logic                                      in_pkt;
	logic                                      corrupt;
	int                                        n_unf;
	int                                        n_mismatch;
	int                                        n_compared;

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	tx_local_segmented_bus_top i_dut (.clock(clock), .rst_n(rst_n), .tx_segment_data(tx_segment_data),
		.tx_segment_valid(tx_segment_valid), .tx_segment_first(tx_segment_first),
		.tx_segment_last(tx_segment_last), .tx_segment_abort(tx_segment_abort),
		.tx_segment_empty_count(tx_segment_empty_count), .tx_accept_ready(tx_accept_ready),
		.tx_overflow_flag(tx_overflow_flag), .tx_underflow_flag(tx_underflow_flag),
		.line_ready(line_ready), .line_valid(line_valid), .line_beat(line_beat),
		.line_error_block(line_error_block), .line_fcs_skip(line_fcs_skip));

	packet_source i_src (.clock(clock), .rst_n(rst_n), .tx_accept_ready(tx_accept_ready),
		.run(run), .obey(obey), .starve(starve), .lag(lag), .seg_data(tx_segment_data),
		.seg_valid(tx_segment_valid), .seg_first(tx_segment_first),
		.seg_last(tx_segment_last), .seg_abort(tx_segment_abort),
		.seg_empty(tx_segment_empty_count), .mid_packet(mid_packet));

	// ------------------------------------------------------------------------
	// Compare and closing tasks
	// ------------------------------------------------------------------------
	task automatic cmp_bit(input string what, input logic exp, input logic got);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic cmp_word(input string what, input logic [127:0] exp, input logic [127:0] got);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic test_done();
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic wait_ready();
		int i;
		for (i = 0; i < 50 && tx_accept_ready !== 1'b1; i++) begin
			@(posedge clock);
		end
		cmp_bit("tx_accept_ready", 1'b1, tx_accept_ready);
		if (tx_accept_ready !== 1'b1) begin
			test_done();
		end
	endtask

	// ------------------------------------------------------------------------
	// Reference model of the line side
	// ------------------------------------------------------------------------
	// Captures pass through pend and pend2, matching the capture register and the
	// buffer write, so the queue holds what the buffer held at the pop edge.
	task automatic check_beat(input beat_t b, input logic unf);
		logic err;
		logic skip;
		logic cut;
		logic [3:0] mty;
		err = unf || corrupt;
		skip = 1'b0;
		cmp_bit("line_valid", 1'b1, line_valid);
		cmp_bit("line_error_block", err, line_error_block);
		for (int s = 0; s < 4; s++) begin
			cut = b[s].abort && b[s].last;
			if (err) begin
				cmp_word("error data", `TX_ERROR_WORD, line_beat[s].data);
			end else if (b[s].valid) begin
				cmp_word("data", cut ? `TX_ERROR_WORD : b[s].data, line_beat[s].data);
				cmp_bit("first", b[s].first, line_beat[s].first);
				cmp_bit("last", b[s].last, line_beat[s].last);
				mty = b[s].last ? b[s].empty_count : 4'h0;
				if (cut) mty[2:0] = 3'h0;
				cmp_word("empty", 128'(mty), 128'(line_beat[s].empty_count));
				skip |= cut;
			end
		end
		if (!err) begin
			cmp_bit("line_fcs_skip", skip, line_fcs_skip);
		end
		if (unf) begin
			corrupt = 1'b1;
			n_unf++;
		end else begin
			for (int s = 0; s < 4; s++) begin
				if (b[s].valid && b[s].first) in_pkt = 1'b1;
				if (b[s].valid && b[s].last) begin
					in_pkt = 1'b0;
					corrupt = 1'b0;
				end
			end
		end
	endtask

	always @(posedge clock) begin
		beat_t b;
		logic  unf;
		unf = 1'b0;
		b = '0;
		if (!chk) begin
			q.delete();
			pend_v = 1'b0;
			pend2_v = 1'b0;
			in_pkt = 1'b0;
			corrupt = 1'b0;
		end else begin
			if (lr_prev && (q.size() > 0 || in_pkt)) begin
				unf = (q.size() == 0);
				if (!unf) b = q.pop_front();
				check_beat(b, unf);
			end else begin
				cmp_bit("line_valid", 1'b0, line_valid);
			end
			cmp_bit("tx_underflow_flag", unf, tx_underflow_flag);
			cmp_bit("tx_overflow_flag", 1'b0, tx_overflow_flag);
			if (pend2_v) q.push_back(pend2);
			pend2 = pend;
			pend2_v = pend_v;
			pend_v = |tx_segment_valid;
			for (int s = 0; s < 4; s++) begin
				pend[s] = {tx_segment_data[s], tx_segment_valid[s], tx_segment_first[s],
					tx_segment_last[s], tx_segment_abort[s], tx_segment_empty_count[s]};
			end
		end
		lr_prev = line_ready;
	end

	// ------------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------------
	initial begin
		int i;
		int k;
		void'($urandom(32'h1f12f605));
		{rst_n, run, starve, lag, line_ready, chk} = '0;
		obey = 1'b1;
		n_unf = 0;
		n_mismatch = 0;
		n_compared = 0;
		repeat (12) @(posedge clock);
		cmp_bit("tx_accept_ready", 1'b0, tx_accept_ready);
		cmp_bit("tx_underflow_flag", 1'b0, tx_underflow_flag);
		rst_n <= 1'b1;
		wait_ready();
		chk <= 1'b1;
		run <= 1'b1;
		repeat (3000) begin
			@(posedge clock);
			line_ready <= ($urandom_range(0, 3) != 0);
			if ($urandom_range(0, 63) == 0) lag <= $urandom_range(0, 2);
		end
		line_ready <= 1'b0;
		repeat (40) @(posedge clock);
		cmp_bit("tx_accept_ready", 1'b0, tx_accept_ready);
		line_ready <= 1'b1;
		wait_ready();
		// The beat launched as starve is raised may close the packet, so retry.
		for (i = 0; i < 8 && n_unf == 0; i++) begin
			for (k = 0; k < 100 && !mid_packet; k++) @(posedge clock);
			cmp_bit("mid_packet", 1'b1, mid_packet);
			if (mid_packet !== 1'b1) begin
				test_done();
			end
			starve <= 1'b1;
			repeat (16) @(posedge clock);
			starve <= 1'b0;
			repeat (60) @(posedge clock);
		end
		repeat (40) @(posedge clock);
		run <= 1'b0;
		repeat (50) @(posedge clock);
		cmp_bit("underflow seen", 1'b1, n_unf > 0);
		chk <= 1'b0;
		obey <= 1'b0;
		line_ready <= 1'b0;
		run <= 1'b1;
		repeat (40) @(posedge clock);
		run <= 1'b0;
		repeat (10) @(posedge clock);
		cmp_bit("tx_overflow_flag", 1'b1, tx_overflow_flag);
		cmp_bit("tx_accept_ready", 1'b0, tx_accept_ready);
		rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		cmp_bit("tx_overflow_flag", 1'b0, tx_overflow_flag);
		rst_n <= 1'b1;
		wait_ready();
		test_done();
	end
endmodule
